// ===== sps_defines.vh
// Shared constants for the stepper phase sequencer: register map, fields, resets and timing
`ifndef SPS_DEFINES_VH
`define SPS_DEFINES_VH

// ****************************************************************************
// Register map (byte addresses, one 32-bit word each)
// ****************************************************************************
`define SPS_ADDR_W          8
`define SPS_ADDR_CTRL       8'h00
`define SPS_ADDR_STATUS     8'h04
`define SPS_ADDR_FAULT      8'h08
`define SPS_ADDR_STEPS      8'h0c
`define SPS_ADDR_POS        8'h10

// ****************************************************************************
// Field positions and reset values
// ****************************************************************************
`define SPS_CTRL_DRIVE_EN   0
`define SPS_CTRL_HOLD       1
`define SPS_CTRL_SOFT_CLR   2
`define SPS_CTRL_RESET      3'h1
`define SPS_STAT_MODE       3
`define SPS_STAT_DIR        4
`define SPS_STAT_CLEAR      5
`define SPS_STAT_GATE_LSB   8
`define SPS_FAULT_NARROW    0
`define SPS_FAULT_SHORT_CLR 1
`define SPS_IDX_HOME        3'h0

// ****************************************************************************
// Timing
// ****************************************************************************
`define SPS_CLK_PERIOD_NS   25
`define SPS_MIN_PULSE_NS    20000
`define SPS_MIN_CLEAR_NS    20000
`define SPS_MIN_PULSE_CYC   ((`SPS_MIN_PULSE_NS + `SPS_CLK_PERIOD_NS - 1) / `SPS_CLK_PERIOD_NS)
`define SPS_MIN_CLEAR_CYC   ((`SPS_MIN_CLEAR_NS + `SPS_CLK_PERIOD_NS - 1) / `SPS_CLK_PERIOD_NS)

`endif

// ===== sps_edge_detect.v
// Registered level follower giving one-cycle rise and fall pulses
`timescale 1ns/1ps
`default_nettype none

module sps_edge_detect #(
  parameter INIT = 1'b1
) (
  input  wire pclk,
  input  wire presetn,
  input  wire level_in,
  output wire rise,
  output wire fall
);

  reg prev_r;

  // Starting high means a level already high at release is not an edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_r <= INIT;
    end else begin
      prev_r <= level_in;
    end
  end

  assign rise = level_in & ~prev_r;
  assign fall = ~level_in & prev_r;

endmodule // sps_edge_detect

`default_nettype wire

// ===== sps_phase_decode.v
// Phase index to gate pattern table for the eight-state sequence
`timescale 1ns/1ps
`default_nettype none

module sps_phase_decode (
  input  wire [2:0] idx,
  output reg  [3:0] gates
);

  // gates = {fourth, third, second, first}; even indices drive two gates
  always @* begin
    case (idx)
      3'h0:    gates = 4'h9;
      3'h1:    gates = 4'h1;
      3'h2:    gates = 4'h3;
      3'h3:    gates = 4'h2;
      3'h4:    gates = 4'h6;
      3'h5:    gates = 4'h4;
      3'h6:    gates = 4'hc;
      3'h7:    gates = 4'h8;
      default: gates = 4'h0;
    endcase
  end
  // First and third never together, nor second and fourth

endmodule // sps_phase_decode

`default_nettype wire

// ===== sps_stepper_top.v
// Stepper phase sequencer with APB register access
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "sps_defines.vh"

module sps_stepper_top #(
  parameter CNT_W = 10
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        step_clock,
  input  wire        excitation_select,
  input  wire        direction_select,
  input  wire        system_clear_low,
  output reg         gate_first,
  output reg         gate_second,
  output reg         gate_third,
  output reg         gate_fourth,
  output reg         winding_one_pos,
  output reg         winding_two_pos,
  output reg         winding_one_neg,
  output reg         winding_two_neg
);

  // **************************************************************************
  // Constants
  // **************************************************************************
  localparam integer     MIN_PULSE_INT = `SPS_MIN_PULSE_CYC;
  localparam integer     MIN_CLEAR_INT = `SPS_MIN_CLEAR_CYC;
  localparam [CNT_W-1:0] MIN_PULSE_CYC = MIN_PULSE_INT[CNT_W-1:0];
  localparam [CNT_W-1:0] MIN_CLEAR_CYC = MIN_CLEAR_INT[CNT_W-1:0];
  localparam [CNT_W-1:0] CNT_ONE       = {{(CNT_W-1){1'b0}}, 1'b1};

  // **************************************************************************
  // State
  // **************************************************************************
  reg  [2:0]       idx_r;
  reg  [2:0]       idx_nxt;
  reg              mode_r;
  reg              mode_nxt;
  reg              dir_r;
  reg              dir_nxt;
  reg  [2:0]       ctrl_r;
  reg  [2:0]       ctrl_nxt;
  reg  [1:0]       fault_r;
  reg  [1:0]       fault_nxt;
  reg  [31:0]      steps_r;
  reg  [31:0]      steps_nxt;
  reg  [31:0]      pos_r;
  reg  [31:0]      pos_nxt;
  reg  [CNT_W-1:0] width_cnt_r;
  reg  [CNT_W-1:0] width_cnt_nxt;
  reg  [CNT_W-1:0] clr_cnt_r;
  reg  [CNT_W-1:0] clr_cnt_nxt;
  reg  [3:0]       gates_nxt;
  reg  [2:0]       step_delta;
  reg              step_go;
  reg  [31:0]      rd_data;
  reg              addr_hit;
  reg  [1:0]       fault_set;
  reg  [1:0]       fault_clr;

  wire             step_rise;
  wire             step_fall;
  wire             clear_rise;
  wire [3:0]       dec_gates;
  wire             seq_clear;
  wire             apb_req;
  wire             apb_done;
  wire             wr_en;
  wire             pready_nxt;

  // **************************************************************************
  // Input edges
  // **************************************************************************
  sps_edge_detect #(
    .INIT (1'b1)
  ) u_step_edge (
    .pclk     (pclk),
    .presetn  (presetn),
    .level_in (step_clock),
    .rise     (step_rise),
    .fall     (step_fall)
  );

  sps_edge_detect #(
    .INIT (1'b1)
  ) u_clear_edge (
    .pclk     (pclk),
    .presetn  (presetn),
    .level_in (system_clear_low),
    .rise     (clear_rise),
    .fall     ()
  );

  // **************************************************************************
  // Phase sequencer
  // **************************************************************************
  assign seq_clear = ~system_clear_low | ctrl_r[`SPS_CTRL_SOFT_CLR];

  always @* begin
    // Odd index in full-step: one move lands back on a two-gate state
    step_delta = (excitation_select | idx_r[0]) ? 3'h1 : 3'h2;
    step_go    = step_rise & ~seq_clear & ~ctrl_r[`SPS_CTRL_HOLD];
    idx_nxt    = idx_r;
    mode_nxt   = mode_r;
    dir_nxt    = dir_r;
    if (seq_clear) begin
      idx_nxt = `SPS_IDX_HOME;
    end else if (step_go) begin
      mode_nxt = excitation_select;
      dir_nxt  = direction_select;
      if (direction_select) begin
        idx_nxt = idx_r - step_delta;
      end else begin
        idx_nxt = idx_r + step_delta;
      end
    end
  end

  sps_phase_decode u_decode (
    .idx   (idx_nxt),
    .gates (dec_gates)
  );

  always @* begin
    if (seq_clear || !ctrl_r[`SPS_CTRL_DRIVE_EN]) begin
      gates_nxt = 4'h0;
    end else begin
      gates_nxt = dec_gates;
    end
  end

  // **************************************************************************
  // Step counters
  // **************************************************************************
  always @* begin
    steps_nxt = steps_r;
    pos_nxt   = pos_r;
    if (wr_en && paddr == `SPS_ADDR_STEPS) begin
      steps_nxt = pwdata;
    end
    if (step_go) begin
      steps_nxt = steps_nxt + 32'h1;
    end
    // Position counts half-steps so both modes share one scale
    if (seq_clear) begin
      pos_nxt = 32'h0;
    end else if (step_go) begin
      if (direction_select) begin
        pos_nxt = pos_r - {29'h0, step_delta};
      end else begin
        pos_nxt = pos_r + {29'h0, step_delta};
      end
    end
  end

  // **************************************************************************
  // Timing monitors on the controller's pins
  // **************************************************************************
  always @* begin
    fault_set = 2'h0;
    // Saturated count avoids a false flag on the first edge
    if (step_rise || step_fall) begin
      width_cnt_nxt = CNT_ONE;
      if (width_cnt_r < MIN_PULSE_CYC) begin
        fault_set[`SPS_FAULT_NARROW] = 1'b1;
      end
    end else if (width_cnt_r < MIN_PULSE_CYC) begin
      width_cnt_nxt = width_cnt_r + CNT_ONE;
    end else begin
      width_cnt_nxt = width_cnt_r;
    end
    if (!system_clear_low) begin
      if (clr_cnt_r < MIN_CLEAR_CYC) begin
        clr_cnt_nxt = clr_cnt_r + CNT_ONE;
      end else begin
        clr_cnt_nxt = clr_cnt_r;
      end
    end else begin
      clr_cnt_nxt = {CNT_W{1'b0}};
    end
    if (clear_rise && clr_cnt_r < MIN_CLEAR_CYC) begin
      fault_set[`SPS_FAULT_SHORT_CLR] = 1'b1;
    end
  end

  // **************************************************************************
  // APB slave
  // **************************************************************************
  // Two-cycle access: pready rises the cycle after penable, for one cycle
  assign apb_req    = psel & penable;
  assign pready_nxt = apb_req & ~pready;
  assign apb_done   = apb_req & pready;
  assign wr_en      = apb_done & pwrite;

  always @* begin
    addr_hit = 1'b1;
    rd_data  = 32'h0;
    case (paddr)
      `SPS_ADDR_CTRL: begin
        rd_data[2:0] = ctrl_r;
      end
      `SPS_ADDR_STATUS: begin
        rd_data[2:0]                 = idx_r;
        rd_data[`SPS_STAT_MODE]      = mode_r;
        rd_data[`SPS_STAT_DIR]       = dir_r;
        rd_data[`SPS_STAT_CLEAR]     = seq_clear;
        rd_data[`SPS_STAT_GATE_LSB]  = gate_first;
        rd_data[`SPS_STAT_GATE_LSB+1] = gate_second;
        rd_data[`SPS_STAT_GATE_LSB+2] = gate_third;
        rd_data[`SPS_STAT_GATE_LSB+3] = gate_fourth;
      end
      `SPS_ADDR_FAULT: begin
        rd_data[1:0] = fault_r;
      end
      `SPS_ADDR_STEPS: begin
        rd_data = steps_r;
      end
      `SPS_ADDR_POS: begin
        rd_data = pos_r;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  always @* begin
    ctrl_nxt  = ctrl_r;
    fault_clr = 2'h0;
    if (wr_en && paddr == `SPS_ADDR_CTRL) begin
      ctrl_nxt = pwdata[2:0];
    end
    if (wr_en && paddr == `SPS_ADDR_FAULT) begin
      fault_clr = pwdata[1:0];
    end
    // A new fault in the clearing cycle survives the clear
    fault_nxt = (fault_r & ~fault_clr) | fault_set;
  end

  // **************************************************************************
  // Registers
  // **************************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx_r           <= `SPS_IDX_HOME;
      mode_r          <= 1'b0;
      dir_r           <= 1'b0;
      ctrl_r          <= `SPS_CTRL_RESET;
      fault_r         <= 2'h0;
      steps_r         <= 32'h0;
      pos_r           <= 32'h0;
      width_cnt_r     <= MIN_PULSE_CYC;
      clr_cnt_r       <= {CNT_W{1'b0}};
      prdata          <= 32'h0;
      pready          <= 1'b0;
      pslverr         <= 1'b0;
      gate_first      <= 1'b0;
      gate_second     <= 1'b0;
      gate_third      <= 1'b0;
      gate_fourth     <= 1'b0;
      winding_one_pos <= 1'b0;
      winding_two_pos <= 1'b0;
      winding_one_neg <= 1'b0;
      winding_two_neg <= 1'b0;
    end else begin
      idx_r           <= idx_nxt;
      mode_r          <= mode_nxt;
      dir_r           <= dir_nxt;
      ctrl_r          <= ctrl_nxt;
      fault_r         <= fault_nxt;
      steps_r         <= steps_nxt;
      pos_r           <= pos_nxt;
      width_cnt_r     <= width_cnt_nxt;
      clr_cnt_r       <= clr_cnt_nxt;
      pready          <= pready_nxt;
      pslverr         <= pready_nxt & ~addr_hit;
      if (pready_nxt && !pwrite) begin
        prdata <= rd_data;
      end
      gate_first      <= gates_nxt[0];
      gate_second     <= gates_nxt[1];
      gate_third      <= gates_nxt[2];
      gate_fourth     <= gates_nxt[3];
      // One winding output per gate
      winding_one_pos <= gates_nxt[0];
      winding_two_pos <= gates_nxt[1];
      winding_one_neg <= gates_nxt[2];
      winding_two_neg <= gates_nxt[3];
    end
  end

endmodule // sps_stepper_top

`default_nettype wire

// ===== sps_stepper_assertions.sv
// Port-level assertions for the stepper phase sequencer
`timescale 1ns/1ps
`default_nettype none
module sps_stepper_assertions #(
  parameter CNT_W = 10
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        step_clock,
  input wire logic        excitation_select,
  input wire logic        direction_select,
  input wire logic        system_clear_low,
  input wire logic        gate_first,
  input wire logic        gate_second,
  input wire logic        gate_third,
  input wire logic        gate_fourth,
  input wire logic        winding_one_pos,
  input wire logic        winding_two_pos,
  input wire logic        winding_one_neg,
  input wire logic        winding_two_neg
);
  logic [3:0] g;
  logic       stp_q;
  logic       clr_q;
  logic       rise;
  logic       live;
  logic [1:0] run_r;
  logic [2:0] ctl_q;
  logic [2:0] ctl_p;
  assign g = {gate_fourth, gate_third, gate_second, gate_first};
  assign rise = step_clock & ~stp_q;
  // Control word must rest at drive on, no hold, no soft clear for two cycles
  assign live = (run_r == 2'h3) & system_clear_low & clr_q & (ctl_q == 3'h1) & (ctl_p == 3'h1);
  // Settle window, so the home load after reset is not taken for a step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stp_q <= 1'h1;
      clr_q <= 1'h0;
      run_r <= 2'h0;
      ctl_q <= 3'h1;
      ctl_p <= 3'h1;
    end else begin
      stp_q <= step_clock;
      clr_q <= system_clear_low;
      ctl_p <= ctl_q;
      if (run_r != 2'h3) run_r <= run_r + 2'h1;
      if (psel && penable && pready && pwrite && paddr == 8'h00) ctl_q <= pwdata[2:0];
    end
  end
  // ********
  // Checks
  // ********
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_gate_map: assert property (g == {winding_two_neg, winding_one_neg, winding_two_pos, winding_one_pos})
    else $error("windings differ from gates");
  a_no_short: assert property (!(gate_first && gate_third) && !(gate_second && gate_fourth))
    else $error("both halves of a winding on");
  a_clear_cuts: assert property (!system_clear_low |=> g == 4'h0)
    else $error("gates on during clear");
  a_ctrl_cuts: assert property (!ctl_q[0] || ctl_q[2] |=> g == 4'h0)
    else $error("gates on while drive off or soft clear");
  a_clear_home: assert property (system_clear_low && !clr_q && run_r == 2'h3 && ctl_q == 3'h1 |=> g == 4'h9)
    else $error("no home pattern after clear");
  a_hold_still: assert property (live && !rise |=> $stable(g))
    else $error("gates moved without a step");
  a_step_moves: assert property (live && rise |=> !$stable(g))
    else $error("step did not move gates");
  a_full_pair: assert property (live && rise && !excitation_select |=> $countones(g) == 2)
    else $error("full step not two gates");
  a_half_alt: assert property (live && rise && excitation_select |=> $countones(g) + $countones($past(g)) == 3)
    else $error("half step did not alternate");
  a_apb_answer: assert property (psel && penable && !pready |=> pready)
    else $error("no answer one cycle after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  c_half: cover property (live && rise && excitation_select);
  c_full: cover property (live && rise && !excitation_select);
  c_err: cover property (pready && pslverr);
  c_clear: cover property (run_r == 2'h3 && clr_q && !system_clear_low);
endmodule // sps_stepper_assertions
bind sps_stepper_top sps_stepper_assertions #(.CNT_W(CNT_W)) i_sps_stepper_assertions (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .step_clock(step_clock), .excitation_select(excitation_select),
  .direction_select(direction_select), .system_clear_low(system_clear_low),
  .gate_first(gate_first), .gate_second(gate_second), .gate_third(gate_third),
  .gate_fourth(gate_fourth), .winding_one_pos(winding_one_pos), .winding_two_pos(winding_two_pos),
  .winding_one_neg(winding_one_neg), .winding_two_neg(winding_two_neg)
);
`default_nettype wire

// ===== sps_host_model.sv
// Host controller model for the step, mode, direction and clear pins
`timescale 1ns/1ps
`default_nettype none
module sps_host_model (
  input  wire logic pclk,
  output var  logic step_clock,
  output var  logic excitation_select,
  output var  logic direction_select,
  output var  logic system_clear_low
);
  // Clear low from power-up so the sequencer always starts at home
  initial begin
    step_clock = 1'h0;
    excitation_select = 1'h0;
    direction_select = 1'h0;
    system_clear_low = 1'h0;
  end
  // Mode and direction move with the rise, where they are sampled
  task automatic pulse(input logic m, input logic d, input int w);
    @(posedge pclk);
    excitation_select <= m;
    direction_select <= d;
    step_clock <= 1'h1;
    repeat (w) @(posedge pclk);
    step_clock <= 1'h0;
    repeat (w) @(posedge pclk);
  endtask
  task automatic hold_clear(input int n);
    @(posedge pclk);
    system_clear_low <= 1'h0;
    repeat (n) @(posedge pclk);
    system_clear_low <= 1'h1;
  endtask
endmodule // sps_host_model
`default_nettype wire

// ===== testbench.sv
// Self-checking testbench for the stepper phase sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, rd;
  logic [2:0]  idx;
  int          error_cnt, tests_run, cyc, pos, ones;
  wire  [31:0] prdata;
  wire         pready, pslverr, step_clock, excitation_select, direction_select, system_clear_low;
  wire         gate_first, gate_second, gate_third, gate_fourth;
  wire         winding_one_pos, winding_two_pos, winding_one_neg, winding_two_neg;
  wire  [3:0]  gts = {gate_fourth, gate_third, gate_second, gate_first};
  wire  [3:0]  wnd = {winding_two_neg, winding_one_neg, winding_two_pos, winding_one_pos};
  logic [3:0]  pat [8] = '{4'h9, 4'h1, 4'h3, 4'h2, 4'h6, 4'h4, 4'hc, 4'h8};
  sps_stepper_top i_sps_stepper_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .step_clock(step_clock), .excitation_select(excitation_select),
    .direction_select(direction_select), .system_clear_low(system_clear_low),
    .gate_first(gate_first), .gate_second(gate_second), .gate_third(gate_third),
    .gate_fourth(gate_fourth), .winding_one_pos(winding_one_pos), .winding_two_pos(winding_two_pos),
    .winding_one_neg(winding_one_neg), .winding_two_neg(winding_two_neg));
  sps_host_model i_sps_host_model (
    .pclk(pclk), .step_clock(step_clock), .excitation_select(excitation_select),
    .direction_select(direction_select), .system_clear_low(system_clear_low));
  always #12.5 pclk = ~pclk;
  // Run needs about 36000 cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      results();
    end
  end
  // ********
  // Tasks
  // ********
  task automatic results;
    if (error_cnt == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      $display("ERROR %s exp %h seen %h", n, e, s);
      error_cnt++;
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic run(input logic m, input logic d, input int n, input int w);
    int dl;
    for (int i = 0; i < n; i++) begin
      dl = m ? 1 : (idx[0] ? 1 : 2);
      i_sps_host_model.pulse(m, d, w);
      pos += d ? -dl : dl;
      idx = d ? idx - 3'(dl) : idx + 3'(dl);
      ones += $countones(gts);
      chk("gates", {28'h0, pat[idx]}, {28'h0, gts});
      chk("windings", {28'h0, pat[idx]}, {28'h0, wnd});
      apb(1'h0, 8'h04, 32'h0);
      chk("status", {27'h0, d, m, idx}, {27'h0, rd[4:0]});
    end
  endtask
  task automatic t_reset;
    chk("home", 32'h9, {28'h0, wnd});
    apb(1'h0, 8'h00, 32'h0);
    chk("ctrl", 32'h1, rd);
    apb(1'h0, 8'h08, 32'h0);
    chk("fault", 32'h0, rd);
    apb(1'h1, 8'h04, 32'hffffffff);
    apb(1'h0, 8'h04, 32'h0);
    chk("status ro", 32'h900, rd & 32'hf27);
    apb(1'h1, 8'h14, 32'h1);
    chk("wr slverr", 32'h1, {31'h0, err});
    apb(1'h0, 8'h14, 32'h0);
    chk("rd slverr", 32'h1, {31'h0, err});
    chk("rd unmapped", 32'h0, rd);
    apb(1'h1, 8'h0c, 32'h5);
    apb(1'h0, 8'h0c, 32'h0);
    chk("steps load", 32'h5, rd);
  endtask
  task automatic t_seq;
    run(1'h1, 1'h0, 8, 800);
    chk("half ones", 32'd12, 32'(ones));
    run(1'h1, 1'h1, 1, 800);
    run(1'h0, 1'h0, 5, 800);
    run(1'h1, 1'h0, 1, 800);
    run(1'h0, 1'h1, 5, 800);
  endtask
  task automatic t_narrow;
    run(1'h0, 1'h0, 1, 10);
    apb(1'h0, 8'h08, 32'h0);
    chk("fault set", 32'h1, rd);
    apb(1'h1, 8'h08, 32'h1);
    apb(1'h0, 8'h08, 32'h0);
    chk("fault w1c", 32'h0, rd);
    apb(1'h0, 8'h0c, 32'h0);
    chk("steps", 32'd26, rd);
    apb(1'h0, 8'h10, 32'h0);
    chk("pos", 32'(pos), rd);
  endtask
  task automatic t_ctrl;
    apb(1'h1, 8'h00, 32'h0);
    repeat (2) @(posedge pclk);
    chk("drive off", 32'h0, {28'h0, gts});
    apb(1'h1, 8'h00, 32'h3);
    repeat (2) @(posedge pclk);
    chk("drive on", 32'h9, {28'h0, gts});
    i_sps_host_model.pulse(1'h0, 1'h0, 800);
    chk("held gates", 32'h9, {28'h0, gts});
    apb(1'h0, 8'h0c, 32'h0);
    chk("held steps", 32'd26, rd);
    apb(1'h1, 8'h00, 32'h5);
    repeat (2) @(posedge pclk);
    chk("soft clear", 32'h0, {28'h0, gts});
    apb(1'h0, 8'h04, 32'h0);
    chk("soft flag", 32'h20, rd & 32'h20);
    apb(1'h1, 8'h00, 32'h1);
    i_sps_host_model.hold_clear(100);
    repeat (2) @(posedge pclk);
    chk("short rehome", 32'h9, {28'h0, gts});
    apb(1'h0, 8'h08, 32'h0);
    chk("short clear", 32'h2, rd);
  endtask
  task automatic t_clear;
    fork
      i_sps_host_model.hold_clear(820);
      begin
        repeat (400) @(posedge pclk);
        chk("cleared", 32'h0, {28'h0, gts});
        apb(1'h0, 8'h04, 32'h0);
        chk("clear flag", 32'h20, rd & 32'h20);
      end
    join
    repeat (2) @(posedge pclk);
    chk("rehome", 32'h9, {28'h0, gts});
    apb(1'h0, 8'h10, 32'h0);
    chk("pos zero", 32'h0, rd);
  endtask
  initial begin
    pclk = 1'h0;
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    error_cnt = 0;
    tests_run = 0;
    cyc = 0;
    idx = 3'h0;
    pos = 0;
    ones = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    i_sps_host_model.hold_clear(820);
    repeat (2) @(posedge pclk);
    t_reset();
    t_seq();
    t_narrow();
    t_clear();
    t_ctrl();
    results();
  end
endmodule // testbench
`default_nettype wire
